// ===== include/dss_defs.svh
/*
  Constants for the drive sequencing state machine: register offsets,
  field positions, reset values and timing counts.
  Assumes inclusion by bare name from package and design files.
*/
`ifndef DSS_DEFS_SVH
`define DSS_DEFS_SVH

// apb register byte offsets
`define DSS_REG_CTRL        8'h00
`define DSS_REG_CMD         8'h04
`define DSS_REG_STAT        8'h08
`define DSS_REG_SWORD       8'h0C

// control register fields
`define DSS_CTRL_REMOTE     0
`define DSS_CTRL_COAST      1
`define DSS_CTRL_RESTORE    2

// command word fields
`define DSS_CMD_RUN         0
`define DSS_CMD_COAST_N     1
`define DSS_CMD_QUICK_N     2
`define DSS_CMD_ENABLE      3
`define DSS_CMD_CLEAR       7
`define DSS_CMD_RESET       16'h0000

// status word fields
`define DSS_SW_SWON_EN      0
`define DSS_SW_SWITCHED     1
`define DSS_SW_RUNNING      2
`define DSS_SW_FAULT        3
`define DSS_SW_COAST_N      4
`define DSS_SW_QUICK_N      5
`define DSS_SW_INHIBIT      6
`define DSS_SW_REMOTE       9

// synchronised pin positions
`define DSS_PIN_RUN         0
`define DSS_PIN_JOG         1
`define DSS_PIN_ENABLE      2
`define DSS_PIN_COAST_N     3
`define DSS_PIN_QUICK_N     4
`define DSS_PIN_CONTACT     5
`define DSS_PIN_CLEAR       6
`define DSS_PIN_TRIP        7

// timing: line switch close timeout
`define DSS_CORE_CLK_HZ     50000000
`define DSS_LS_TIMEOUT_S    10
`define DSS_LS_TIMEOUT_CYC  (`DSS_LS_TIMEOUT_S * `DSS_CORE_CLK_HZ)

`endif

// ===== include/dss_pkg.sv
/*
  Types for the drive sequencing state machine.
  Assumes dss_defs.svh is on the include path.
*/
`default_nettype none
`include "dss_defs.svh"

package dss_pkg;

  // main state, value readable by software
  typedef enum logic [2:0] {
    DSS_INHIBIT = 3'b000,
    DSS_ARMED   = 3'b001,
    DSS_POWERED = 3'b010,
    DSS_READY   = 3'b011,
    DSS_OPER    = 3'b100,
    DSS_QHALT   = 3'b101,
    DSS_FENTRY  = 3'b110,
    DSS_FHOLD   = 3'b111
  } dss_state_e;

  // whole state of the sequencer module
  typedef struct packed {
    logic [7:0]  s1;
    logic [7:0]  s2;
    logic [7:0]  s3;
    logic [7:0]  flt;
    dss_state_e  state;
    logic        clr_prev;
    logic        run_prev;
    logic        jog_prev;
    logic        inch;
    logic        stop;
    logic        hlth_hold;
    logic        line_sw;
    logic [8:0]  outs;
    logic        remote;
    logic        halt_coast;
    logic        restore;
    logic [15:0] cmd;
    logic [31:0] prdata;
    logic [31:0] ls_cnt;
  } dss_state_s;

endpackage

`default_nettype wire

// ===== rtl/dss_sequencer.sv
/*
  Drive sequencing state machine with an apb register slave.
  Assumes pins arrive asynchronously, motor-control indications arrive
  as levels on i_core_clk, and an apb master with zero-wait slaves.
*/
// Our own choices: the APB interface to the registers and the address map.
// Operation
// - main state readable as 0..7 value
// - fault, active, halting follow their states
// - armed, powered, ready true up to fault-entry
// - inch raised from inch start to end
// - halting during stop cycles and quick-halt
// - fault-hold healthy once run, inch false
// - lowest numbered transition wins
// - inhibit on power-up or configuration restore
// - inhibit to armed when idle, halts high
// - trip moves to fault-entry; open switch trips
// - switch unclosed ten seconds trips powered state
// - halt request returns armed, powered, ready to inhibit
// - run or inch moves armed to powered
// - no request falls powered, ready to armed
// - closed switch and defluxed gives ready
// - enable toggles ready and operating
// - coast to inhibit, quick to quick-halt
// - idle and stop done gives armed
// - quick-halt leaves on timer, coast, zero
// - fault-entry to fault-hold once stack quenched
// - fault-hold cleared by clear edge, no trip
// - switch-on accepted only in armed state
// - remote command bits ANDed with local halts
// - remote fault clear from command bit 7
// - status inhibit bit only in inhibit
`timescale 1ns/1ns
`default_nettype none
`include "dss_defs.svh"

module dss_sequencer #(
  parameter int unsigned P_LS_TIMEOUT_CYC = `DSS_LS_TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_nrst,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // local command pins, asynchronous
  input  wire logic        i_run,
  input  wire logic        i_jog,
  input  wire logic        i_enable,
  input  wire logic        i_coast_halt_n,
  input  wire logic        i_quick_halt_n,
  input  wire logic        i_contactor_closed,
  input  wire logic        i_fault_clear,
  input  wire logic        i_trip,
  // motor-control indications, same clock
  input  wire logic        i_defluxed,
  input  wire logic        i_stop_complete,
  input  wire logic        i_qh_timer_expired,
  input  wire logic        i_at_zero_setpoint,
  input  wire logic        i_stack_quenched,
  input  wire logic        i_config_restore,
  // state outputs
  output logic [2:0]       o_main_state_value,
  output logic             o_fault,
  output logic             o_active,
  output logic             o_inch,
  output logic             o_halting,
  output logic             o_line_switch,
  output logic             o_armed,
  output logic             o_powered,
  output logic             o_ready,
  output logic             o_healthy
);

  dss_pkg::dss_state_s q;
  dss_pkg::dss_state_s d;

  logic [7:0]  pins;
  logic        run_r;
  logic        jog_r;
  logic        en_r;
  logic        coast_n_r;
  logic        quick_n_r;
  logic        clr_r;
  logic        trip_r;
  logic        contact_r;
  logic        idle_r;
  logic        halt_r;
  logic        clr_rise;
  logic        ls_timeout;
  logic        restore_r;
  logic [15:0] sword;
  logic [31:0] stat;

  // level vector order: fault active armed powered ready quick-halt,
  // each computed from a state alone
  function automatic logic [5:0] lvl_of(input dss_pkg::dss_state_e s);
    logic [5:0] r;
    r = 6'h00;
    r[5] = (s == dss_pkg::DSS_FENTRY) || (s == dss_pkg::DSS_FHOLD);
    r[4] = (s == dss_pkg::DSS_OPER);
    r[3] = (s != dss_pkg::DSS_INHIBIT) && (s != dss_pkg::DSS_FHOLD);
    r[2] = r[3] && (s != dss_pkg::DSS_ARMED);
    r[1] = r[2] && (s != dss_pkg::DSS_POWERED);
    r[0] = (s == dss_pkg::DSS_QHALT);
    return r;
  endfunction

  // address decode used only for the slave error response
  function automatic logic mapped(input logic [7:0] a);
    return (a == `DSS_REG_CTRL) || (a == `DSS_REG_CMD) ||
           (a == `DSS_REG_STAT) || (a == `DSS_REG_SWORD);
  endfunction

  // effective commands: filtered pins, combined with remote word
  assign pins      = q.flt;
  assign run_r     = q.remote ? q.cmd[`DSS_CMD_RUN] : pins[`DSS_PIN_RUN];
  assign jog_r     = q.remote ? 1'b0 : pins[`DSS_PIN_JOG];
  assign coast_n_r = pins[`DSS_PIN_COAST_N] &
                     (~q.remote | q.cmd[`DSS_CMD_COAST_N]);
  assign quick_n_r = pins[`DSS_PIN_QUICK_N] &
                     (~q.remote | q.cmd[`DSS_CMD_QUICK_N]);
  assign en_r      = pins[`DSS_PIN_ENABLE] &
                     (~q.remote | q.cmd[`DSS_CMD_ENABLE]);
  assign clr_r     = q.remote ? q.cmd[`DSS_CMD_CLEAR]
                              : pins[`DSS_PIN_CLEAR];
  assign trip_r    = pins[`DSS_PIN_TRIP];
  assign contact_r = pins[`DSS_PIN_CONTACT];
  assign idle_r    = ~run_r & ~jog_r;
  assign halt_r    = ~coast_n_r | ~quick_n_r;
  assign clr_rise  = clr_r & ~q.clr_prev;
  assign restore_r = i_config_restore | q.restore;
  assign ls_timeout = (q.ls_cnt >= (P_LS_TIMEOUT_CYC - 32'd1));

  // status word and block status for software
  always_comb begin
    sword = 16'h0000;
    sword[`DSS_SW_SWON_EN]  = q.outs[3];
    sword[`DSS_SW_SWITCHED] = q.outs[2];
    sword[`DSS_SW_RUNNING]  = q.outs[7];
    sword[`DSS_SW_FAULT]    = q.outs[8];
    sword[`DSS_SW_COAST_N]  = coast_n_r;
    sword[`DSS_SW_QUICK_N]  = quick_n_r;
    sword[`DSS_SW_INHIBIT]  = (q.state == dss_pkg::DSS_INHIBIT);
    sword[`DSS_SW_REMOTE]   = q.remote;
    stat = {20'h0_0000, q.outs, q.state};
  end

  // next state of the whole module
  always_comb begin
    logic [5:0] lv;
    logic       op_wr;
    d = q;
    lv = 6'h00;
    op_wr = i_psel & i_penable & i_pwrite;
    // three-stage pin synchroniser, value taken when stages agree
    d.s1 = {i_trip, i_fault_clear, i_contactor_closed, i_quick_halt_n,
            i_coast_halt_n, i_enable, i_jog, i_run};
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < 8; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.flt[i] = q.s3[i];
      end
    end
    d.clr_prev = clr_r;
    d.run_prev = run_r;
    d.jog_prev = jog_r;
    d.restore  = 1'b0;
    // apb register writes, pready is always high
    if (op_wr && (i_paddr == `DSS_REG_CTRL)) begin
      d.remote     = i_pwdata[`DSS_CTRL_REMOTE];
      d.halt_coast = i_pwdata[`DSS_CTRL_COAST];
      d.restore    = i_pwdata[`DSS_CTRL_RESTORE];
    end
    if (op_wr && (i_paddr == `DSS_REG_CMD)) begin
      d.cmd = i_pwdata[15:0];
    end
    // read data captured in the setup phase
    if (i_psel && !i_penable) begin
      case (i_paddr)
        `DSS_REG_CTRL:  d.prdata = {29'h0000_0000, 1'b0,
                                    q.halt_coast, q.remote};
        `DSS_REG_CMD:   d.prdata = {16'h0000, q.cmd};
        `DSS_REG_STAT:  d.prdata = stat;
        `DSS_REG_SWORD: d.prdata = {16'h0000, sword};
        default:        d.prdata = 32'h0000_0000;
      endcase
    end
    // line switch close timer while powered and switch open
    if ((q.state == dss_pkg::DSS_POWERED) && !contact_r && !ls_timeout)
    begin
      d.ls_cnt = q.ls_cnt + 32'd1;
    end else if (q.state != dss_pkg::DSS_POWERED || contact_r) begin
      d.ls_cnt = 32'h0000_0000;
    end
    // transitions, tested in ascending number order
    if (restore_r) begin
      d.state = dss_pkg::DSS_INHIBIT;
    end else begin
      case (q.state)
        dss_pkg::DSS_INHIBIT: begin
          if (trip_r) begin
            d.state = dss_pkg::DSS_FENTRY;
          end else if (idle_r && !halt_r) begin
            d.state = dss_pkg::DSS_ARMED;
          end
        end
        dss_pkg::DSS_ARMED: begin
          if (trip_r) begin
            d.state = dss_pkg::DSS_FENTRY;
          end else if (halt_r) begin
            d.state = dss_pkg::DSS_INHIBIT;
          end else if (!idle_r) begin
            d.state = dss_pkg::DSS_POWERED;
          end
        end
        dss_pkg::DSS_POWERED: begin
          if (trip_r || ls_timeout) begin
            d.state = dss_pkg::DSS_FENTRY;
          end else if (halt_r) begin
            d.state = dss_pkg::DSS_INHIBIT;
          end else if (idle_r) begin
            d.state = dss_pkg::DSS_ARMED;
          end else if (contact_r && i_defluxed) begin
            d.state = dss_pkg::DSS_READY;
          end
        end
        dss_pkg::DSS_READY: begin
          if (trip_r || !contact_r) begin
            d.state = dss_pkg::DSS_FENTRY;
          end else if (halt_r) begin
            d.state = dss_pkg::DSS_INHIBIT;
          end else if (idle_r) begin
            d.state = dss_pkg::DSS_ARMED;
          end else if (en_r) begin
            d.state = dss_pkg::DSS_OPER;
          end
        end
        dss_pkg::DSS_OPER: begin
          if (trip_r || !contact_r) begin
            d.state = dss_pkg::DSS_FENTRY;
          end else if (!coast_n_r) begin
            d.state = dss_pkg::DSS_INHIBIT;
          end else if (!quick_n_r) begin
            d.state = dss_pkg::DSS_QHALT;
          end else if (idle_r && i_stop_complete) begin
            d.state = dss_pkg::DSS_ARMED;
          end else if (!en_r) begin
            d.state = dss_pkg::DSS_READY;
          end
        end
        dss_pkg::DSS_QHALT: begin
          if (trip_r || !contact_r) begin
            d.state = dss_pkg::DSS_FENTRY;
          end else if (i_qh_timer_expired || q.halt_coast ||
                       i_at_zero_setpoint) begin
            d.state = dss_pkg::DSS_INHIBIT;
          end
        end
        dss_pkg::DSS_FENTRY: begin
          if (i_stack_quenched) begin
            d.state = dss_pkg::DSS_FHOLD;
          end
        end
        dss_pkg::DSS_FHOLD: begin
          if (!trip_r && clr_rise) begin
            d.state = dss_pkg::DSS_INHIBIT;
          end
        end
        default: d.state = dss_pkg::DSS_INHIBIT;
      endcase
    end
    // inch and stop cycles live only in the operating state
    if (d.state != dss_pkg::DSS_OPER) begin
      d.inch = 1'b0;
      d.stop = 1'b0;
    end else begin
      if (jog_r && !q.jog_prev) begin
        d.inch = 1'b1;
      end else if (i_stop_complete || run_r) begin
        d.inch = 1'b0;
      end
      if ((q.run_prev && !run_r) || (q.jog_prev && !jog_r)) begin
        d.stop = 1'b1;
      end else if (i_stop_complete || !idle_r) begin
        d.stop = 1'b0;
      end
    end
    // healthy hold in fault-hold once run and inch fall
    if (d.state != dss_pkg::DSS_FHOLD) begin
      d.hlth_hold = 1'b0;
    end else if (idle_r) begin
      d.hlth_hold = 1'b1;
    end
    // line switch: held in inhibit and armed
    lv = lvl_of(d.state);
    if (d.state == dss_pkg::DSS_FHOLD) begin
      d.line_sw = 1'b0;
    end else if (lv[2]) begin
      d.line_sw = 1'b1;
    end
    d.outs = {lv[5], lv[4], d.inch, lv[0] | d.stop, d.line_sw,
              lv[3], lv[2], lv[1],
              (d.state != dss_pkg::DSS_FENTRY) &&
              ((d.state != dss_pkg::DSS_FHOLD) || d.hlth_hold)};
  end

  // state register
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flip-flops, apart from constant pready and decoded pslverr
  assign o_main_state_value = q.state;
  assign o_fault       = q.outs[8];
  assign o_active      = q.outs[7];
  assign o_inch        = q.outs[6];
  assign o_halting     = q.outs[5];
  assign o_line_switch = q.outs[4];
  assign o_armed       = q.outs[3];
  assign o_powered     = q.outs[2];
  assign o_ready       = q.outs[1];
  assign o_healthy     = q.outs[0];
  assign o_prdata      = q.prdata;
  assign o_pready      = 1'b1;
  assign o_pslverr     = i_psel & i_penable & ~mapped(i_paddr);

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  // fault path steps
  sequence s_in_entry_quenched;
    (q.state == dss_pkg::DSS_FENTRY) && i_stack_quenched && !restore_r;
  endsequence
  sequence s_hold_cleared;
    (q.state == dss_pkg::DSS_FHOLD) && !trip_r && clr_rise && !restore_r;
  endsequence

  a_fault_flag_states: assert property (
    o_fault == (q.state inside {dss_pkg::DSS_FENTRY, dss_pkg::DSS_FHOLD}))
    else $error("fault flag outside fault states");
  a_active_only_oper: assert property (
    o_active |-> q.state == dss_pkg::DSS_OPER)
    else $error("active outside operating");
  a_levels_off_idle: assert property (
    (q.state inside {dss_pkg::DSS_INHIBIT, dss_pkg::DSS_FHOLD}) |->
    !o_armed && !o_powered && !o_ready)
    else $error("level output in inhibit or fault-hold");
  a_trip_enters_fault: assert property (
    (trip_r && !restore_r && q.state inside {dss_pkg::DSS_INHIBIT,
     dss_pkg::DSS_ARMED, dss_pkg::DSS_POWERED, dss_pkg::DSS_READY,
     dss_pkg::DSS_OPER, dss_pkg::DSS_QHALT})
    |=> q.state == dss_pkg::DSS_FENTRY ##0 o_fault && !o_healthy)
    else $error("trip did not reach fault-entry");
  a_quench_to_hold: assert property (
    s_in_entry_quenched |=> q.state == dss_pkg::DSS_FHOLD)
    else $error("quench did not reach fault-hold");
  a_clear_leaves_hold: assert property (
    s_hold_cleared |=> q.state == dss_pkg::DSS_INHIBIT ##1 !o_fault)
    else $error("fault clear edge ignored");
  a_hold_stays: assert property (
    (q.state == dss_pkg::DSS_FHOLD && !clr_rise && !restore_r)
    |=> q.state == dss_pkg::DSS_FHOLD)
    else $error("fault-hold left without clear edge");
  a_halt_to_inhibit: assert property (
    (q.state == dss_pkg::DSS_ARMED && halt_r && !trip_r && !restore_r)
    |=> q.state == dss_pkg::DSS_INHIBIT)
    else $error("halt request did not inhibit");
  a_remote_and_coast: assert property (
    q.remote |-> coast_n_r == (q.cmd[1] & pins[`DSS_PIN_COAST_N]))
    else $error("remote coast halt not combined");
  a_inhibit_bit: assert property (
    $rose(q.state == dss_pkg::DSS_INHIBIT) |-> sword[6] [*1] ##1
    (sword[6] == (q.state == dss_pkg::DSS_INHIBIT)))
    else $error("inhibit status bit wrong");

endmodule

`default_nettype wire

// ===== dv/dss_plc_model.sv
/*
  Behavioural controller for the drive sequencer: drives the command
  pins and the motor-control indications as one vector of levels.
  Assumes the bench calls put and clear_pulse from one thread only.
*/
`timescale 1ns/1ns
`default_nettype none

module dss_plc_model (
  // clock
  input  wire logic   i_clk,
  // command pins and indications, positions as the pin constants
  output var logic [13:0] o_ctl
);
  // halts inactive, every other line low
  initial o_ctl = 14'h0018;

  // lines change just after an edge, so they stay clocked levels
  task automatic put(input logic [13:0] m, input logic [13:0] v);
    @(posedge i_clk);
    o_ctl <= (o_ctl & ~m) | (v & m);
  endtask

  // a clean low then high, each held past the pin filter
  task automatic clear_pulse();
    put(14'h0040, 14'h0000);
    repeat (6) @(posedge i_clk);
    put(14'h0040, 14'h0040);
  endtask
endmodule

`default_nettype wire

// ===== dv/test_dss_sequencer.sv
/*
  Self-checking bench for the drive sequencer: walks the main states
  with pin commands and apb accesses and compares the state outputs.
  Assumes dss_plc_model drives the pins; the apb slave adds no wait states.
*/
`timescale 1ns/1ns
`default_nettype none
`include "dss_defs.svh"

module test_dss_sequencer;
  // indication positions above the synchronised pins
  localparam int B_QEXP = 10;
  localparam int B_QNCH = 12;
  localparam int B_STOP = 9;

  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] rd;
  logic        er;
  int          failures = 0;
  int          num_checks = 0;
  wire logic [13:0] ctl;
  wire logic [31:0] prdata;
  wire logic [2:0]  st;
  wire logic  pready, pslverr, fault, active, inch, halting;
  wire logic  lsw, armed, powered, ready, healthy;

  // 50 MHz clock
  always #10 clk = ~clk;

  dss_plc_model i_plc (.i_clk(clk), .o_ctl(ctl));

  dss_sequencer #(.P_LS_TIMEOUT_CYC(20)) i_dut (
    .i_core_clk(clk), .i_nrst(nrst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_run(ctl[0]), .i_jog(ctl[1]),
    .i_enable(ctl[2]), .i_coast_halt_n(ctl[3]),
    .i_quick_halt_n(ctl[4]), .i_contactor_closed(ctl[5]),
    .i_fault_clear(ctl[6]), .i_trip(ctl[7]), .i_defluxed(ctl[8]),
    .i_stop_complete(ctl[9]), .i_qh_timer_expired(ctl[10]),
    .i_at_zero_setpoint(ctl[11]), .i_stack_quenched(ctl[12]),
    .i_config_restore(ctl[13]), .o_main_state_value(st),
    .o_fault(fault), .o_active(active), .o_inch(inch),
    .o_halting(halting), .o_line_switch(lsw), .o_armed(armed),
    .o_powered(powered), .o_ready(ready), .o_healthy(healthy)
  );

  // one comparison, counted
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic pin(input int b, input logic v);
    i_plc.put(14'h0001 << b, {14{v}});
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // wait, bounded, for a main state, then compare it
  task automatic ws(input logic [2:0] s);
    int n;
    n = 0;
    while (st !== s && n < 60) begin
      @(negedge clk);
      n++;
    end
    cmp(st, s);
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // from inhibit or armed up to operating: run, enable, closed, defluxed
  task automatic go_oper();
    pin(`DSS_PIN_RUN, 1'b0);
    ws(3'h1);
    i_plc.put(14'h0125, 14'h0125);
    ws(3'h4);
  endtask

  task automatic give_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    repeat (8000) @(posedge clk);
    failures++;
    give_verdict();
  end

  // main sequence
  initial begin
    int i;
    pin(`DSS_PIN_RUN, 1'b1);
    repeat (20) @(posedge clk);
    cmp({st, fault, active, armed, lsw}, 7'h00);
    nrst <= 1'b1;
    idle(12);
    cmp(st, 3'h0);
    pin(`DSS_PIN_RUN, 1'b0);
    ws(3'h1);
    cmp({armed, powered, lsw}, 3'b100);
    apb(1'b0, `DSS_REG_STAT, 32'h0000_0000);
    cmp({rd[6], rd[2:0]}, 4'h9);
    apb(1'b0, 8'h10, 32'h0000_0000);
    cmp({er, rd}, 33'h1_0000_0000);
    // powered while the line switch never closes
    pin(`DSS_PIN_RUN, 1'b1);
    ws(3'h2);
    cmp(lsw, 1'b1);
    ws(3'h6);
    cmp({fault, armed, ready, healthy}, 4'b1110);
    pin(B_QNCH, 1'b1);
    ws(3'h7);
    cmp({fault, armed, lsw, healthy}, 4'b1000);
    i_plc.put(14'h1001, 14'h0000);
    idle(8);
    cmp(healthy, 1'b1);
    i_plc.clear_pulse();
    ws(3'h0);
    ws(3'h1);
    pin(`DSS_PIN_RUN, 1'b1);
    ws(3'h2);
    pin(`DSS_PIN_COAST_N, 1'b0);
    ws(3'h0);
    cmp(lsw, 1'b1);
    pin(`DSS_PIN_COAST_N, 1'b1);
    idle(10);
    cmp(st, 3'h0);
    go_oper();
    cmp({active, ready, lsw}, 3'b111);
    pin(`DSS_PIN_ENABLE, 1'b0);
    ws(3'h3);
    pin(`DSS_PIN_ENABLE, 1'b1);
    ws(3'h4);
    // run dropped as jog rises: a held run request would end the inch
    i_plc.put(14'h0003, 14'h0002);
    idle(8);
    cmp(inch, 1'b1);
    i_plc.put(14'h0003, 14'h0000);
    idle(8);
    cmp({st, halting}, 4'h9);
    pin(B_STOP, 1'b1);
    ws(3'h1);
    pin(B_STOP, 1'b0);
    // quick halt left by timer, zero setpoint, then coast style
    for (i = 0; i < 3; i++) begin
      go_oper();
      pin(`DSS_PIN_QUICK_N, 1'b0);
      ws(3'h5);
      cmp({active, halting}, 2'b01);
      if (i < 2)
        pin(B_QEXP + i, 1'b1);
      else
        apb(1'b1, `DSS_REG_CTRL, 32'h0000_0002);
      ws(3'h0);
      i_plc.put(14'h0c10, 14'h0010);
    end
    // trip and coast halt on the same edge
    go_oper();
    i_plc.put(14'h0088, 14'h0080);
    ws(3'h6);
    i_plc.put(14'h1089, 14'h1008);
    ws(3'h7);
    pin(B_QNCH, 1'b0);
    i_plc.clear_pulse();
    ws(3'h0);
    ws(3'h1);
    // remote command word
    apb(1'b1, `DSS_REG_CTRL, 32'h0000_0001);
    apb(1'b1, `DSS_REG_CMD, 32'h0000_0000);
    ws(3'h0);
    apb(1'b0, `DSS_REG_SWORD, 32'h0000_0000);
    cmp({rd[9], rd[6], rd[4]}, 3'b110);
    apb(1'b1, `DSS_REG_CMD, 32'h0000_0006);
    ws(3'h1);
    apb(1'b0, `DSS_REG_SWORD, 32'h0000_0000);
    cmp(rd[6], 1'b0);
    pin(`DSS_PIN_TRIP, 1'b1);
    ws(3'h6);
    i_plc.put(14'h1080, 14'h1000);
    ws(3'h7);
    pin(B_QNCH, 1'b0);
    apb(1'b1, `DSS_REG_CMD, 32'h0000_0086);
    ws(3'h0);
    // configuration restore through the control register
    apb(1'b1, `DSS_REG_CTRL, 32'h0000_0000);
    ws(3'h1);
    apb(1'b1, `DSS_REG_CTRL, 32'h0000_0004);
    ws(3'h0);
    give_verdict();
  end
endmodule

`default_nettype wire
